// >>> core/btce_exec.v
`include "btce_defs.vh"
module btce_exec (
  // Clock, reset, enable
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  input  wire       ce_i,
  // Instruction from fetch
  input  wire       instr_valid_i,
  input  wire [2:0] opcode_i,
  input  wire [7:0] imm_i,
  input  wire [5:0] reg_addr_i,
  input  wire [2:0] bit_sel_i,
  // File register read data for reg_addr_i
  input  wire [7:0] reg_rdata_i,
  // Core context
  input  wire [7:0] pc_high_buffer_i,
  input  wire [7:0] table_high_pointer_i,
  input  wire [2:0] stack_rd_addr_i,
  // File register write
  output reg        reg_we_o,
  output reg  [5:0] reg_waddr_o,
  output reg  [7:0] reg_wdata_o,
  // Architectural state
  output reg  [7:0] accumulator_o,
  output reg        zero_flag_o,
  output reg  [8:0] pc_o,
  output reg  [2:0] stack_ptr_o,
  output wire [8:0] stack_rdata_o,
  // Pipeline control
  output wire       busy_o,
  output reg        flush_o
);
  reg        state_ff;
  reg        nxt_state;
  reg  [7:0] acc_ff;
  reg  [7:0] nxt_acc;
  reg        z_ff;
  reg        nxt_z;
  reg  [8:0] pc_ff;
  reg  [8:0] nxt_pc;
  reg  [2:0] sp_ff;
  reg  [2:0] nxt_sp;
  reg        push;
  reg        nxt_we;
  reg  [7:0] nxt_wdata;
  wire       sel_bit;
  wire [7:0] sel_mask;
  wire [7:0] set_data;
  genvar     gi;

  // One-hot mask of the selected bit, used by set and test.
  function [7:0] bit_mask;
    input [2:0] b;
    begin
      bit_mask = 8'h01 << b;
    end
  endfunction

  assign sel_mask = bit_mask(bit_sel_i);
  assign sel_bit  = |(reg_rdata_i & sel_mask);

  // Each lane keeps its read bit or forces it high, so only one bit can ever change.
  generate
    for (gi = 0; gi < `BTCE_DATA_W; gi = gi + 1) begin : g_set_lane
      assign set_data[gi] = reg_rdata_i[gi] | sel_mask[gi]; // RL2
    end
  endgenerate
  // Fetch must hold the next instruction while a skip or call occupies its second cycle.
  assign busy_o  = (state_ff == `BTCE_ST_WAIT);

  always @* begin
    nxt_state = `BTCE_ST_RUN;
    nxt_acc   = acc_ff;
    nxt_z     = z_ff;
    nxt_pc    = pc_ff;
    nxt_sp    = sp_ff;
    push      = 1'b0;
    nxt_we    = 1'b0;
    nxt_wdata = reg_rdata_i;
    case (state_ff)
      `BTCE_ST_RUN: begin
        if (instr_valid_i) begin
          nxt_pc = pc_ff + `BTCE_PC_ONE;
          case (opcode_i)
            `BTCE_OP_ANDI: begin
              nxt_acc = acc_ff & imm_i; // RL1
              nxt_z   = ~|(acc_ff & imm_i); // RL1
            end
            `BTCE_OP_BSET: begin
              nxt_we    = 1'b1;
              nxt_wdata = set_data; // RL2
            end
            `BTCE_OP_TSTZ: begin
              if (!sel_bit) begin
                nxt_state = `BTCE_ST_WAIT; // RL3
              end
            end
            `BTCE_OP_TSTO: begin
              if (sel_bit) begin
                nxt_state = `BTCE_ST_WAIT; // RL4
              end
            end
            `BTCE_OP_CALL: begin
              push      = 1'b1; // RL6
              nxt_sp    = sp_ff + `BTCE_SP_ONE; // RL9
              nxt_pc    = {pc_high_buffer_i[0], imm_i}; // RL7
              nxt_state = `BTCE_ST_WAIT; // RL6
            end
            `BTCE_OP_CALL_VIA_ACCUMULATOR: begin
              push      = 1'b1; // RL6
              nxt_sp    = sp_ff + `BTCE_SP_ONE; // RL9
              nxt_pc    = {table_high_pointer_i[0], acc_ff}; // RL8
              nxt_state = `BTCE_ST_WAIT; // RL6
            end
            default: begin
              nxt_pc = pc_ff + `BTCE_PC_ONE;
            end
          endcase
        end
      end
      `BTCE_ST_WAIT: begin
        // Discarded slot runs as a no-operation; fetch steps over the dropped word itself.
        nxt_state = `BTCE_ST_RUN; // RL5
      end
      default: begin
        nxt_state = `BTCE_ST_RUN;
      end
    endcase
  end

  // Every register holds still while ce_i is low, so a stalled core loses nothing.
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= `BTCE_ST_RUN;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_ff <= `BTCE_ACC_RST;
    end else if (ce_i) begin
      acc_ff <= nxt_acc; // RL1
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      z_ff <= `BTCE_Z_RST;
    end else if (ce_i) begin
      z_ff <= nxt_z; // RL9
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_ff <= `BTCE_PC_RST;
    end else if (ce_i) begin
      pc_ff <= nxt_pc;
    end
  end

  // The pointer wraps silently at the stack depth; deep nesting overwrites old entries.
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sp_ff <= `BTCE_SP_RST;
    end else if (ce_i) begin
      sp_ff <= nxt_sp; // RL9
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_we_o <= 1'b0;
    end else if (ce_i) begin
      reg_we_o <= nxt_we; // RL2
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_waddr_o <= `BTCE_WADDR_RST;
    end else if (ce_i) begin
      reg_waddr_o <= reg_addr_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_wdata_o <= `BTCE_WDATA_RST;
    end else if (ce_i) begin
      reg_wdata_o <= nxt_wdata;
    end
  end

  // Registered so that fetch sees the drop marker together with busy_o.
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flush_o <= 1'b0;
    end else if (ce_i) begin
      flush_o <= (nxt_state == `BTCE_ST_WAIT); // RL5
    end
  end

  always @* begin
    accumulator_o = acc_ff;
    zero_flag_o   = z_ff;
    pc_o          = pc_ff;
    stack_ptr_o   = sp_ff;
  end

  // Return address is written at the old pointer, then the pointer moves on.
  btce_stack_mem u_stack (
    .sys_clk_i (sys_clk_i),
    .ce_i      (ce_i),
    .wr_en_i   (push & ce_i), // RL6
    .wr_addr_i (sp_ff),
    .wr_data_i (pc_ff + `BTCE_PC_ONE), // RL6
    .rd_addr_i (stack_rd_addr_i),
    .rd_data_o (stack_rdata_o)
  );
endmodule // btce_exec

// >>> core/btce_defs.vh
`ifndef BTCE_DEFS_VH
`define BTCE_DEFS_VH
// Summary of operation
// [RL1] AND accumulator with 8-bit immediate, write back, update zero flag, one cycle.
// [RL2] Set selected bit 0..7 of file register 0..63, others unchanged, one cycle.
// [RL3] Skip next instruction when selected register bit reads zero.
// [RL4] Skip next instruction when selected register bit reads one.
// [RL5] A skip discards the fetched instruction and runs a no-operation: two cycles.
// [RL6] Both calls push program counter plus one onto stack; each takes two cycles.
// [RL7] Direct call loads immediate into PC[7:0] and high buffer bit 0 into PC[8].
// [RL8] Computed call loads pointer bit 0 into PC[8] and accumulator into PC[7:0].
// [RL9] Calls bump the stack pointer after storing; bit operations leave flags unchanged.
`define BTCE_OP_NONE    3'h0
`define BTCE_OP_ANDI    3'h1
`define BTCE_OP_BSET    3'h2
`define BTCE_OP_TSTZ    3'h3
`define BTCE_OP_TSTO    3'h4
`define BTCE_OP_CALL    3'h5
`define BTCE_OP_CALL_VIA_ACCUMULATOR   3'h6
`define BTCE_PC_W       9
`define BTCE_PC_ONE     9'h001
`define BTCE_SP_W       3
`define BTCE_SP_ONE     3'h1
`define BTCE_STK_DEPTH  8
`define BTCE_ACC_RST    8'h00
`define BTCE_PC_RST     9'h000
`define BTCE_SP_RST     3'h0
`define BTCE_ST_RUN     1'b0
`define BTCE_ST_WAIT    1'b1
`define BTCE_DATA_W     8
`define BTCE_Z_RST      1'b0
`define BTCE_WADDR_RST  6'h00
`define BTCE_WDATA_RST  8'h00
`endif

// >>> core/btce_stack_mem.v
module btce_stack_mem (
  // Clock and clock enable
  input  wire       sys_clk_i,
  input  wire       ce_i,
  // Write port
  input  wire       wr_en_i,
  input  wire [2:0] wr_addr_i,
  input  wire [8:0] wr_data_i,
  // Registered read port
  input  wire [2:0] rd_addr_i,
  output reg  [8:0] rd_data_o
);
  reg [8:0] mem [0:7];
  always @(posedge sys_clk_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule // btce_stack_mem

// >>> tb/btce_exec_chk.sv
module btce_exec_chk (
  input wire logic       sys_clk_i, rst_b_i, ce_i, instr_valid_i, reg_we_o, zero_flag_o, busy_o,
  input wire logic       flush_o,
  input wire logic [2:0] opcode_i, bit_sel_i, stack_ptr_o,
  input wire logic [5:0] reg_addr_i, reg_waddr_o,
  input wire logic [7:0] imm_i, reg_rdata_i, pc_high_buffer_i, table_high_pointer_i,
  input wire logic [7:0] reg_wdata_o, accumulator_o,
  input wire logic [8:0] pc_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire tk = ce_i && instr_valid_i && !busy_o;
  wire bv = reg_rdata_i[bit_sel_i];
  // Skip and call both spend exactly one extra slot.
  sequence s_two; busy_o && flush_o ##1 !busy_o; endsequence
  a_andi_val: assert property (tk && opcode_i == 3'h1 |=>
    accumulator_o == ($past(accumulator_o) & $past(imm_i))) else $error("and value");
  a_andi_zero: assert property (tk && opcode_i == 3'h1 |=>
    zero_flag_o == (accumulator_o == 8'h00)) else $error("zero flag");
  a_bset_wr: assert property (tk && opcode_i == 3'h2 |=> reg_we_o &&
    reg_waddr_o == $past(reg_addr_i) &&
    reg_wdata_o == ($past(reg_rdata_i) | (8'h01 << $past(bit_sel_i)))) else $error("bit set");
  a_skip_taken: assert property (tk && (opcode_i == 3'h3 && !bv || opcode_i == 3'h4 && bv)
    |=> s_two) else $error("skip");
  a_skip_not: assert property (tk && (opcode_i == 3'h3 && bv || opcode_i == 3'h4 && !bv)
    |=> !busy_o) else $error("no skip");
  a_call_push: assert property (tk && (opcode_i == 3'h5 || opcode_i == 3'h6) |=>
    stack_ptr_o == $past(stack_ptr_o) + 3'h1 ##0 s_two) else $error("push");
  a_call_dir: assert property (tk && opcode_i == 3'h5 |=>
    pc_o == {$past(pc_high_buffer_i[0]), $past(imm_i)}) else $error("call target");
  a_call_acc: assert property (tk && opcode_i == 3'h6 |=>
    pc_o == {$past(table_high_pointer_i[0]), $past(accumulator_o)}) else $error("call_via_accumulator target");
  a_flag_kept: assert property (tk && opcode_i inside {3'h2, 3'h3, 3'h4} |=>
    $stable(zero_flag_o)) else $error("flag moved");
endmodule // btce_exec_chk
bind btce_exec btce_exec_chk chk_u (.*);

// >>> tb/test_mcu_bit_test_and_call_exec.sv
module test_mcu_bit_test_and_call_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk_i = 0, rst_b_i = 0, ce_i = 1, instr_valid_i = 0;
  logic [2:0] opcode_i = 0, bit_sel_i = 0, stack_rd_addr_i = 0, q;
  logic [5:0] reg_addr_i = 6'h3f;
  logic [7:0] imm_i = 0, reg_rdata_i = 0, pc_high_buffer_i = 8'h01, table_high_pointer_i = 8'h01;
  logic [8:0] p;
  wire        reg_we_o, zero_flag_o, busy_o, flush_o;
  wire  [5:0] reg_waddr_o;
  wire  [7:0] reg_wdata_o, accumulator_o;
  wire  [8:0] pc_o, stack_rdata_o;
  wire  [2:0] stack_ptr_o;
  int         n_errors = 0, total_checks = 0;
  btce_exec dut_u (.*);
  always #4 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [8:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Presents one instruction for a single slot, then idles.
  task automatic go(input logic [2:0] o, input logic [7:0] i, d, input logic [2:0] b);
    @(negedge sys_clk_i);
    {opcode_i, imm_i, reg_rdata_i, bit_sel_i, instr_valid_i} = {o, i, d, b, 1'b1};
    p = pc_o;
    q = stack_ptr_o;
    @(negedge sys_clk_i);
    instr_valid_i = 0;
  endtask
  task automatic t_andi;
    go(3'h1, 8'haf, 8'h00, 3'h0);
    chk(accumulator_o, 9'h000);
    chk(zero_flag_o, 9'h001);
  endtask
  task automatic t_bset;
    for (int b = 0; b < 8; b++) begin
      go(3'h2, 8'h00, 8'h5a, b[2:0]);
      chk({reg_we_o, reg_wdata_o}, {1'b1, 8'h5a | (8'h01 << b)});
      chk(reg_waddr_o, 9'h03f);
      chk(zero_flag_o, 9'h001);
    end
  endtask
  task automatic t_skip;
    for (int k = 0; k < 4; k++) begin
      go(3'h3 + k[1], 8'h00, k[0] ? 8'h04 : 8'hfb, 3'h2);
      chk(busy_o, k[1] == k[0]);
      chk(flush_o, k[1] == k[0]);
      chk(pc_o, p + 9'h001);
      @(negedge sys_clk_i);
      chk(busy_o, 9'h000);
    end
  endtask
  task automatic t_call(input logic [2:0] o, input logic [8:0] e);
    go(o, 8'ha5, 8'h00, 3'h0);
    chk(pc_o, e);
    chk({busy_o, stack_ptr_o}, {1'b1, q + 3'h1});
    stack_rd_addr_i = q;
    @(negedge sys_clk_i);
    chk(stack_rdata_o, p + 9'h001);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge sys_clk_i);
    rst_b_i = 1;
    chk(pc_o, 9'h000);
    t_andi();
    t_bset();
    t_skip();
    t_call(3'h5, 9'h1a5);
    t_call(3'h6, 9'h100);
    give_verdict();
  end
endmodule // test_mcu_bit_test_and_call_exec
